// file: hw/scs_spi_port.sv
// clock-stop spi engine, master and slave, clock polarity zero
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - the generated serial clock period is divider plus one system clocks.
// - the low phase is half the period, or divider/2 clocks when the divider is even.
// - the high phase is half the period, or divider/2 plus one when even.
// - as master the frame sync output is inverted to form an active-low enable.
// - as slave the active-low enable input is inverted before internal use.
// - as master tx clock and tx sync are outputs and rx clock and rx sync inputs.
// - as slave all four direction settings are inputs.
// - the enable goes low before the first rising clock edge that starts the word.
// - master lead time is one low phase in mode 10b and one period in mode 11b.
// - in mode 10b data is sampled on falling edges and changes after rising edges.
// - in mode 11b data is sampled on rising edges and changes after falling edges.
// - master holds enable one period in 10b and one low phase in 11b after the last fall.
// - in 10b the master releases data one low phase after the last falling edge.
// - as slave data is driven after enable falls and released after it rises.
module scs_spi_port #(
	parameter int WORD_W = scs_pkg::WORD_W,
	parameter int DIV_W = scs_pkg::DIV_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic master_i,
	input wire logic [1:0] clock_stop_mode_select_i,
	input wire logic [DIV_W-1:0] sample_clock_divider_i,
	input wire logic sample_clock_source_select_i,
	input wire logic tx_frame_sync_polarity_i,
	input wire logic rx_frame_sync_polarity_i,
	input wire logic start_i,
	input wire logic [WORD_W-1:0] tx_word_i,
	output logic [WORD_W-1:0] rx_word_o,
	output logic rx_valid_o,
	output logic busy_o,
	output logic cfg_error_o,
	output logic tx_clock_direction_o,
	output logic rx_clock_direction_o,
	output logic tx_frame_sync_direction_o,
	output logic rx_frame_sync_direction_o,
	input wire logic tx_serial_clock_pin_i,
	output logic tx_serial_clock_pin_o,
	output logic tx_serial_clock_pin_oe_o,
	input wire logic tx_frame_sync_pin_i,
	output logic tx_frame_sync_pin_o,
	output logic tx_frame_sync_pin_oe_o,
	input wire logic rx_frame_sync_pin_i,
	input wire logic serial_data_in_pin_i,
	output logic serial_data_out_pin_o,
	output logic serial_data_out_pin_oe_o
);
	scs_pkg::scs_state_t state_q, state_d;
	logic [WORD_W-1:0] tx_sh_q, rx_sh_q, rx_word_q;
	logic [scs_pkg::CNT_W-1:0] bits_q;
	logic [1:0] ph_q;
	logic rx_valid_q, oe_q, sclk_run, tick, sclk_lvl;
	logic mode11, m_sample, m_shift, s_rise, s_fall, s_en, s_en_q;
	logic s_sample, s_shift, last_bit, fs_active;
	logic [DIV_W:0] per_w;
	logic [DIV_W-1:0] hi_len_w, lead_q;
	logic lead_hold, done_bits;

	assign mode11 = (clock_stop_mode_select_i == scs_pkg::MODE_DELAY);
	// 11b lead: hold the divider for one high phase, then its low phase ends the lead
	assign per_w = {1'b0, sample_clock_divider_i} + (DIV_W+1)'(1);
	assign hi_len_w = DIV_W'(per_w - {1'b0, per_w[DIV_W:1]});
	assign lead_hold = mode11 && (state_q == scs_pkg::SCS_LEAD) && (lead_q != hi_len_w);
	assign sclk_run = master_i && (state_q != scs_pkg::SCS_IDLE) && !lead_hold;

	scs_clkgen #(.DIV_W(DIV_W)) u_clk (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.run_i(sclk_run),
		.sample_clock_divider_i(sample_clock_divider_i),
		.tick_o(tick),
		.level_o(sclk_lvl)
	);

	scs_edge u_edge (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.sig_i(tx_serial_clock_pin_i),
		.rise_o(s_rise),
		.fall_o(s_fall)
	);

	// tx directions follow the role, rx directions are always inputs
	assign tx_clock_direction_o = master_i ? scs_pkg::DIR_OUT : scs_pkg::DIR_IN;
	assign tx_frame_sync_direction_o = master_i ? scs_pkg::DIR_OUT : scs_pkg::DIR_IN;
	assign rx_clock_direction_o = scs_pkg::DIR_IN;
	assign rx_frame_sync_direction_o = scs_pkg::DIR_IN;
	// slave clocking is only specified at half rate
	assign cfg_error_o = !master_i && (sample_clock_divider_i != scs_pkg::SLAVE_DIV
		|| sample_clock_source_select_i != scs_pkg::SLAVE_SRC);

	// slave enable after inversion of the active-low input
	assign s_en = !master_i && (tx_frame_sync_polarity_i ? !tx_frame_sync_pin_i
		: tx_frame_sync_pin_i) && (rx_frame_sync_polarity_i ? !rx_frame_sync_pin_i
		: rx_frame_sync_pin_i);

	// master sample/shift points in its own clock phases
	// in 11b the first rise is the lead's last tick, so it samples too
	assign m_sample = tick && (state_q == scs_pkg::SCS_SHIFT
		|| (mode11 && state_q == scs_pkg::SCS_LEAD)) && (mode11 ? !sclk_lvl : sclk_lvl);
	assign m_shift = tick && (state_q == scs_pkg::SCS_SHIFT) && (mode11 ? sclk_lvl : !sclk_lvl);
	assign s_sample = s_en && (mode11 ? s_rise : s_fall);
	assign s_shift = s_en && (mode11 ? s_fall : s_rise);
	assign last_bit = (bits_q == scs_pkg::CNT_W'(WORD_W - 1));
	assign done_bits = (bits_q == scs_pkg::CNT_W'(WORD_W));

	// master frame sync active in lead, shift and tail
	assign fs_active = master_i && (state_q == scs_pkg::SCS_LEAD
		|| state_q == scs_pkg::SCS_SHIFT || state_q == scs_pkg::SCS_TAIL);
	assign tx_frame_sync_pin_o = tx_frame_sync_polarity_i ? !fs_active : fs_active;
	assign tx_frame_sync_pin_oe_o = master_i;
	// clock forced low outside the shift window
	assign tx_serial_clock_pin_o = (state_q == scs_pkg::SCS_SHIFT) && sclk_lvl;
	assign tx_serial_clock_pin_oe_o = master_i;
	assign serial_data_out_pin_o = tx_sh_q[WORD_W-1];
	assign serial_data_out_pin_oe_o = oe_q;
	assign rx_word_o = rx_word_q;
	assign rx_valid_o = rx_valid_q;
	assign busy_o = (state_q != scs_pkg::SCS_IDLE) || s_en;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			scs_pkg::SCS_IDLE: if (master_i && start_i) state_d = scs_pkg::SCS_LEAD;
			// lead of one low phase (10b) or a whole period (11b)
			scs_pkg::SCS_LEAD: if (tick)
				state_d = scs_pkg::SCS_SHIFT;
			// 10b ends on the last sampling fall, 11b on the fall after the last rise
			scs_pkg::SCS_SHIFT: if (mode11 ? (tick && sclk_lvl && done_bits)
				: (m_sample && last_bit))
				state_d = scs_pkg::SCS_TAIL;
			// tail of one period (10b) or one low phase (11b)
			scs_pkg::SCS_TAIL: if (tick && (ph_q == (mode11 ? 2'h0 : 2'h1)))
				state_d = scs_pkg::SCS_GAP;
			scs_pkg::SCS_GAP: state_d = scs_pkg::SCS_IDLE;
			default: state_d = scs_pkg::SCS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || (!master_i && state_q != scs_pkg::SCS_IDLE)) begin
			state_q <= scs_pkg::SCS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || state_q != state_d) begin
			ph_q <= 2'h0;
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || state_q != scs_pkg::SCS_LEAD) begin
			lead_q <= '0;
		end else if (lead_hold) begin
			lead_q <= lead_q + DIV_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_en_q <= 1'b0;
		end else begin
			s_en_q <= s_en;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_sh_q <= '0;
			rx_sh_q <= '0;
			rx_word_q <= '0;
			bits_q <= '0;
			rx_valid_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			rx_valid_q <= 1'b0;
			if ((master_i && state_q == scs_pkg::SCS_IDLE && start_i)
				|| (s_en && !s_en_q)) begin
				tx_sh_q <= tx_word_i;
				bits_q <= '0;
				oe_q <= 1'b1;
			end else if (master_i ? m_sample : s_sample) begin
				rx_sh_q <= {rx_sh_q[WORD_W-2:0], serial_data_in_pin_i};
				if (last_bit) begin
					rx_word_q <= {rx_sh_q[WORD_W-2:0], serial_data_in_pin_i};
					rx_valid_q <= 1'b1;
				end
				bits_q <= done_bits ? bits_q : bits_q + scs_pkg::CNT_W'(1);
			end else if ((master_i ? m_shift : s_shift) && bits_q != '0) begin
				tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
			end
			if (master_i && state_q == scs_pkg::SCS_TAIL && tick && !mode11)
				oe_q <= 1'b0;
			else if (master_i && state_q == scs_pkg::SCS_GAP)
				oe_q <= 1'b0;
			else if (!master_i && !s_en && s_en_q)
				oe_q <= 1'b0;
		end
	end

	a_fs_before_clk: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		master_i && $rose(tx_serial_clock_pin_o) |-> fs_active)
		else $error("clock rose without enable");
	a_idle_clk_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		state_q == scs_pkg::SCS_IDLE |-> !tx_serial_clock_pin_o)
		else $error("clock toggles while idle");
	a_slave_dirs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!master_i |-> !tx_clock_direction_o && !tx_frame_sync_direction_o)
		else $error("slave direction wrong");
	a_master_dirs: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		master_i |-> tx_clock_direction_o && !rx_clock_direction_o)
		else $error("master direction wrong");
	a_fs_invert: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		master_i && tx_frame_sync_polarity_i && fs_active |-> !tx_frame_sync_pin_o)
		else $error("enable not active low");
	a_slave_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!master_i && $fell(s_en) |=> !serial_data_out_pin_oe_o)
		else $error("slave kept driving");
	a_lead_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$rose(fs_active) |-> ##[1:600] state_q == scs_pkg::SCS_SHIFT)
		else $error("lead too long");
	a_slave_cfg: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!master_i && sample_clock_divider_i != scs_pkg::SLAVE_DIV |-> cfg_error_o)
		else $error("bad slave clock not flagged");
	c_master_word: cover property (@(posedge clk_sys_i) master_i && rx_valid_q);
	c_slave_word: cover property (@(posedge clk_sys_i) !master_i && rx_valid_q);
	c_mode11: cover property (@(posedge clk_sys_i) mode11 && state_q == scs_pkg::SCS_TAIL);
endmodule
`default_nettype wire

// file: hw/scs_pkg.sv
// constants for the clock-stop spi port
package scs_pkg;
	localparam int WORD_W = 16;
	localparam int DIV_W = 8;
	localparam int CNT_W = 5;
	localparam logic [1:0] MODE_NODELAY = 2'h2;
	localparam logic [1:0] MODE_DELAY = 2'h3;
	localparam logic [7:0] SLAVE_DIV = 8'h01;
	localparam logic SLAVE_SRC = 1'h1;
	localparam logic DIR_OUT = 1'h1;
	localparam logic DIR_IN = 1'h0;
	typedef enum logic [2:0] {
		SCS_IDLE = 3'h0,
		SCS_LEAD = 3'h1,
		SCS_SHIFT = 3'h2,
		SCS_TAIL = 3'h3,
		SCS_GAP = 3'h4
	} scs_state_t;
endpackage

// file: hw/scs_clkgen.sv
// divider that makes the sample rate clock phases
`timescale 1ns/1ps
`default_nettype none
module scs_clkgen #(
	parameter int DIV_W = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [DIV_W-1:0] sample_clock_divider_i,
	output logic tick_o,
	output logic level_o
);
	// period is divider+1 cycles; high phase gets the extra cycle
	logic [DIV_W-1:0] cnt_q;
	logic level_q;
	logic [DIV_W-1:0] low_len;
	logic [DIV_W-1:0] high_len;
	logic [DIV_W:0] per;
	assign per = {1'b0, sample_clock_divider_i} + 1'b1;
	assign low_len = (per[DIV_W:1] == '0) ? DIV_W'(1) : per[DIV_W:1];
	assign high_len = DIV_W'(per - {1'b0, low_len}) == '0 ? DIV_W'(1)
		: DIV_W'(per - {1'b0, low_len});
	assign tick_o = run_i && (cnt_q == (level_q ? high_len : low_len) - DIV_W'(1));
	assign level_o = level_q;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= '0;
			level_q <= 1'b0;
		end else if (tick_o) begin
			cnt_q <= '0;
			level_q <= ~level_q;
		end else begin
			cnt_q <= cnt_q + DIV_W'(1);
		end
	end
	a_phase_even: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		run_i && !sample_clock_divider_i[0] && sample_clock_divider_i != '0
		|-> low_len == (sample_clock_divider_i >> 1)
		&& high_len == (sample_clock_divider_i >> 1) + DIV_W'(1))
		else $error("even divider phase error");
	a_phase_odd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		run_i && sample_clock_divider_i[0]
		|-> low_len == high_len && {1'b0, low_len} + {1'b0, high_len} == per)
		else $error("odd divider phase error");
endmodule
`default_nettype wire

// file: hw/scs_edge.sv
// edge detector for the sampled external serial clock
`timescale 1ns/1ps
`default_nettype none
module scs_edge (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sig_i,
	output logic rise_o,
	output logic fall_o
);
	logic prev_q;
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sig_i;
		end
	end
	assign rise_o = sig_i && !prev_q;
	assign fall_o = !sig_i && prev_q;
endmodule
`default_nettype wire

// file: verif/scs_peer.sv
// spi slave peer facing the port in its master role
`timescale 1ns/1ps
`default_nettype none
module scs_peer (
	input wire logic sck_i,
	input wire logic sel_n_i,
	input wire logic dly_i,
	input wire logic [15:0] word_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic [15:0] got_o
);
	logic [15:0] sh;
	initial miso_o = 1'h0;
	// nothing moves before the enable falls
	always @(negedge sel_n_i) begin
		sh = word_i;
		if (dly_i) miso_o = sh[15];
	end
	always @(posedge sck_i) if (!sel_n_i) begin
		if (dly_i) got_o = {got_o[14:0], mosi_i};
		else begin
			miso_o = sh[15];
			sh = sh << 1;
		end
	end
	always @(negedge sck_i) if (!sel_n_i) begin
		if (!dly_i) got_o = {got_o[14:0], mosi_i};
		else begin
			sh = sh << 1;
			miso_o = sh[15];
		end
	end
	// no pull on the line, so a released line must not hold its value
	always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule
`default_nettype wire

// file: verif/serial_port_spi_clock_stop_mode_tb.sv
// bench for the clock-stop spi port
`timescale 1ns/1ps
`default_nettype none
module serial_port_spi_clock_stop_mode_tb;
	logic clk_sys_i = 1'h0;
	logic rst_i = 1'h1;
	logic mst = 1'h1, start = 1'h0, sck_in = 1'h0, en_in = 1'h1, sdi = 1'h0;
	logic srcs = 1'h0, fsp = 1'h1, pc = 1'h0, pe = 1'h1, po = 1'h0;
	logic [1:0] mode = scs_pkg::MODE_NODELAY;
	logic [7:0] div = 8'h03;
	logic [15:0] txw = 16'h0000, pw = 16'h0000, rxw, got;
	logic rxv, busy, cerr, dtc, drc, dtf, drf, sck_o, sck_oe, en_o, en_oe, sdo, sdo_oe, miso;
	int miscompares = 0, check_count = 0, cyc = 0;
	int t_en, t_r1, t_rr, t_f, t_hi, t_lo, t_oe, t_up, n_r;
	wire logic sck_w = sck_oe ? sck_o : sck_in;
	wire logic en_w = en_oe ? en_o : en_in;
	wire logic sdi_w = mst ? miso : sdi;
	scs_spi_port i_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .master_i(mst),
		.clock_stop_mode_select_i(mode), .sample_clock_divider_i(div),
		.sample_clock_source_select_i(srcs), .tx_frame_sync_polarity_i(fsp),
		.rx_frame_sync_polarity_i(fsp), .start_i(start), .tx_word_i(txw),
		.rx_word_o(rxw), .rx_valid_o(rxv), .busy_o(busy), .cfg_error_o(cerr),
		.tx_clock_direction_o(dtc), .rx_clock_direction_o(drc),
		.tx_frame_sync_direction_o(dtf), .rx_frame_sync_direction_o(drf),
		.tx_serial_clock_pin_i(sck_w), .tx_serial_clock_pin_o(sck_o),
		.tx_serial_clock_pin_oe_o(sck_oe), .tx_frame_sync_pin_i(en_w),
		.tx_frame_sync_pin_o(en_o), .tx_frame_sync_pin_oe_o(en_oe),
		.rx_frame_sync_pin_i(en_w), .serial_data_in_pin_i(sdi_w),
		.serial_data_out_pin_o(sdo), .serial_data_out_pin_oe_o(sdo_oe)
	);
	scs_peer i_peer (.sck_i(sck_w), .sel_n_i(en_w), .dly_i(mode[0]), .word_i(pw),
		.mosi_i(sdo), .miso_o(miso), .got_o(got));
	always #2 clk_sys_i = ~clk_sys_i;
	// edge timestamps of the wire, in system clocks
	always @(posedge clk_sys_i) begin
		cyc++;
		if (pe && !en_w) begin
			t_en = cyc;
			n_r = 0;
		end
		if (!pc && sck_w) begin
			if (n_r == 0) t_r1 = cyc;
			else t_lo = cyc - t_f;
			n_r++;
			t_rr = cyc;
		end
		if (pc && !sck_w) begin
			t_f = cyc;
			t_hi = cyc - t_rr;
		end
		if (!pe && en_w) t_up = cyc;
		if (po && !sdo_oe) t_oe = cyc;
		pc = sck_w;
		pe = en_w;
		po = sdo_oe;
		if (cyc > 30000) begin
			miscompares++;
			final_report;
		end
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_n(input string nm, input int e, input int g);
		check_count++;
		if (g != e) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task final_report;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task mword(input logic [1:0] m, input logic [7:0] d, input logic [15:0] tw, w);
		int tp, c, k;
		tp = d + 1;
		c = (d[0] || d == 0) ? tp / 2 : d / 2;
		mode = m;
		div = d;
		txw = tw;
		pw = w;
		@(negedge clk_sys_i);
		start = 1'h1;
		@(negedge clk_sys_i);
		start = 1'h0;
		// a second start in mid-word must be ignored
		repeat (3) @(negedge clk_sys_i);
		start = 1'h1;
		@(negedge clk_sys_i);
		start = 1'h0;
		k = 0;
		while (busy && k < 2000) begin
			@(negedge clk_sys_i);
			k++;
		end
		repeat (2) @(negedge clk_sys_i);
		chk("rx word", w, rxw);
		chk("peer word", tw, got);
		chk_n("rises", 16, n_r);
		chk_n("high", tp - c, t_hi);
		chk_n("low", c, t_lo);
		chk_n("lead", m[0] ? tp : c, t_r1 - t_en);
		chk_n("hold", m[0] ? c : tp, t_up - t_f);
		if (!m[0]) chk_n("release", c, t_oe - t_f);
		chk("idle clk", 16'h0000, {15'h0000, sck_o});
		chk("idle en", 16'h0001, {15'h0000, en_o});
	endtask
	task sword(input logic dl, input logic [15:0] w);
		logic [15:0] sh, gs;
		int i;
		sh = w;
		gs = 16'h0000;
		en_in = 1'h0;
		if (dl) sdi = sh[15];
		repeat (8) @(negedge clk_sys_i);
		chk("slave oe", 16'h0001, {15'h0000, sdo_oe});
		for (i = 0; i < 16; i++) begin
			sck_in = 1'h1;
			if (dl) gs = {gs[14:0], sdo};
			else begin
				sdi = sh[15];
				sh = sh << 1;
			end
			repeat (8) @(negedge clk_sys_i);
			sck_in = 1'h0;
			if (!dl) gs = {gs[14:0], sdo};
			else begin
				sh = sh << 1;
				sdi = sh[15];
			end
			repeat (8) @(negedge clk_sys_i);
		end
		en_in = 1'h1;
		sdi = ~sdi;
		repeat (8) @(negedge clk_sys_i);
		chk("slave oe off", 16'h0000, {15'h0000, sdo_oe});
		chk("slave rx", w, rxw);
		chk("slave tx", txw, gs);
	endtask
	initial begin
		repeat (2) @(negedge clk_sys_i);
		rst_i = 1'h0;
		@(negedge clk_sys_i);
		chk("dir master", 16'h000A, {12'h000, dtc, drc, dtf, drf});
		mword(scs_pkg::MODE_NODELAY, 8'h03, 16'hA5C3, 16'h3C5A);
		mword(scs_pkg::MODE_NODELAY, 8'h02, 16'h8001, 16'h7FFE);
		mword(scs_pkg::MODE_DELAY, 8'h03, 16'h1234, 16'hFEDC);
		mword(scs_pkg::MODE_DELAY, 8'h04, 16'hFFFF, 16'h0000);
		mst = 1'h0;
		div = 8'h02;
		@(negedge clk_sys_i);
		chk("dir slave", 16'h0000, {12'h000, dtc, drc, dtf, drf});
		chk("cfg bad", 16'h0001, {15'h0000, cerr});
		div = scs_pkg::SLAVE_DIV;
		srcs = scs_pkg::SLAVE_SRC;
		@(negedge clk_sys_i);
		chk("cfg ok", 16'h0000, {15'h0000, cerr});
		txw = 16'hC0DE;
		mode = scs_pkg::MODE_NODELAY;
		sword(1'h0, 16'h5AA5);
		txw = 16'h0F1E;
		mode = scs_pkg::MODE_DELAY;
		sword(1'h1, 16'hB00C);
		final_report;
	end
endmodule
`default_nettype wire
